// *** rcad_pkg.sv ***
// rcad_pkg: constants shared by the receive aligner/decoder and its decoder slice.
// assumes one 200 MHz clock, one received serial bit taken per clock cycle.
package rcad_pkg;

  // clock and timing
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          POR_MAX_NS     = 1000000;
  localparam int          POR_MAX_CYCLES = POR_MAX_NS / CLK_PERIOD_NS;
  localparam int          POR_WORDS      = 1024;
  localparam int          BIT_CLK_MULT   = 10;
  localparam int          BITS_PER_BCLK  = 2;
  localparam int          WORD_BITS      = BIT_CLK_MULT * BITS_PER_BCLK;
  localparam int          POR_CYCLES     = POR_WORDS * WORD_BITS;

  // word framing, bit index of the current bit within a 20-bit word
  localparam logic [4:0]  PH_LAST        = 5'h13;
  localparam logic [4:0]  PH_ALIGN       = 5'h06;
  localparam logic [4:0]  PH_ALIGN_HI    = 5'h10;
  localparam logic [4:0]  PH_CLK_RISE    = 5'h05;
  localparam logic [4:0]  PH_CLK_FALL    = 5'h0f;

  // comma 0011111 as it sits in the shift window, oldest bit at the bottom
  localparam logic [6:0]  COMMA_PAT      = 7'h7c;

  // special bytes
  localparam logic [7:0]  K_ERR_BYTE     = 8'h00;
  localparam logic [15:0] LOS_WORD       = 16'hffff;

  // register map, byte addresses
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_MASK      = 8'h08;
  localparam logic [7:0]  ADDR_STATE     = 8'h0c;

  // control bits and reset value
  localparam int          CTRL_ENABLE    = 0;
  localparam int          CTRL_PRBS      = 1;
  localparam int          CTRL_LOOP      = 2;
  localparam logic [2:0]  CTRL_RST       = 3'h1;

  // status / mask bits
  localparam int          ST_REALIGN     = 0;
  localparam int          ST_DEC_ERR     = 1;
  localparam int          ST_LOS         = 2;
  localparam int          ST_PRBS_ERR    = 3;
  localparam int          ST_POR_DONE    = 4;
  localparam int          ST_BITS        = 5;
  localparam logic [4:0]  MASK_RST       = 5'h00;

endpackage

// *** rcad_dec_if.sv ***
// rcad_dec_if: one 10-bit symbol into a decoder slice and the byte out of it.
// assumes the symbol is bit-aligned, first received bit in bit 0.
`timescale 1ns/1ps
interface rcad_dec_if;
  logic [9:0] code;
  logic [7:0] data;
  logic       kflag;
  logic       err;

  modport host (output code, input data, kflag, err);
  modport dec  (input code, output data, kflag, err);
endinterface

// *** rcad_decoder.sv ***
// rcad_decoder: combinational 10b to 8b decode of one symbol.
// assumes code bit 0 is bit a, the first on the line; running disparity is not checked.
`timescale 1ns/1ps
module rcad_decoder
(
  // symbol in, byte out
  rcad_dec_if.dec d
);

  logic [5:0] c6;
  logic [3:0] c4;
  logic [3:0] c4x;
  logic       k28;
  logic       a7;
  logic [4:0] x5;
  logic [2:0] y3;
  logic       bad6;
  logic       bad4;
  logic       kx7;

  // reorder into the usual abcdei / fghj spelling
  assign c6  = {d.code[0], d.code[1], d.code[2], d.code[3], d.code[4], d.code[5]};
  assign c4  = {d.code[6], d.code[7], d.code[8], d.code[9]};
  assign k28 = (c6 == 6'h0f) || (c6 == 6'h30);
  // positive-disparity K28 carries inverted fghj
  assign c4x = (c6 == 6'h30) ? ~c4 : c4;
  assign a7  = (c4x == 4'h7) || (c4x == 4'h8);
  assign kx7 = a7 && ((x5 == 5'h17) || (x5 == 5'h1b) || (x5 == 5'h1d) || (x5 == 5'h1e));

  // 6b to 5b
  always_comb
  begin
    bad6 = 1'b0;
    unique case (c6)
      6'h27, 6'h18: x5 = 5'h00;
      6'h1d, 6'h22: x5 = 5'h01;
      6'h2d, 6'h12: x5 = 5'h02;
      6'h31:        x5 = 5'h03;
      6'h35, 6'h0a: x5 = 5'h04;
      6'h29:        x5 = 5'h05;
      6'h19:        x5 = 5'h06;
      6'h38, 6'h07: x5 = 5'h07;
      6'h39, 6'h06: x5 = 5'h08;
      6'h25:        x5 = 5'h09;
      6'h15:        x5 = 5'h0a;
      6'h34:        x5 = 5'h0b;
      6'h0d:        x5 = 5'h0c;
      6'h2c:        x5 = 5'h0d;
      6'h1c:        x5 = 5'h0e;
      6'h17, 6'h28: x5 = 5'h0f;
      6'h1b, 6'h24: x5 = 5'h10;
      6'h23:        x5 = 5'h11;
      6'h13:        x5 = 5'h12;
      6'h32:        x5 = 5'h13;
      6'h0b:        x5 = 5'h14;
      6'h2a:        x5 = 5'h15;
      6'h1a:        x5 = 5'h16;
      6'h3a, 6'h05: x5 = 5'h17;
      6'h33, 6'h0c: x5 = 5'h18;
      6'h26:        x5 = 5'h19;
      6'h16:        x5 = 5'h1a;
      6'h36, 6'h09: x5 = 5'h1b;
      6'h0e, 6'h0f, 6'h30: x5 = 5'h1c;
      6'h2e, 6'h11: x5 = 5'h1d;
      6'h1e, 6'h21: x5 = 5'h1e;
      6'h2b, 6'h14: x5 = 5'h1f;
      default:
      begin
        x5   = 5'h00;
        bad6 = 1'b1;
      end
    endcase
  end

  // 4b to 3b
  always_comb
  begin
    bad4 = 1'b0;
    unique case (c4x)
      4'hb, 4'h4: y3 = 3'h0;
      4'h9:       y3 = 3'h1;
      4'h5:       y3 = 3'h2;
      4'hc, 4'h3: y3 = 3'h3;
      4'hd, 4'h2: y3 = 3'h4;
      4'ha:       y3 = 3'h5;
      4'h6:       y3 = 3'h6;
      4'he, 4'h1, 4'h7, 4'h8: y3 = 3'h7;
      default:
      begin
        y3   = 3'h0;
        bad4 = 1'b1;
      end
    endcase
  end

  // only K28.y and K23/27/29/30.7 pass as control, anything bad becomes K0.0
  assign d.err   = bad6 | bad4;                                         // see R6
  assign d.kflag = d.err | k28 | kx7;                                   // see R7
  assign d.data  = d.err ? rcad_pkg::K_ERR_BYTE : {y3, x5};             // see R7

endmodule

// *** rcad_rx_align.sv ***
// rcad_rx_align: receive comma alignment, two-slice decode, status pins and registers.
// assumes one serial bit per ref_clk_i cycle from the line or the internal transmit
// stream; the transmitter supplies PRBS data on tx_serial_i while PRBS is enabled.
//
// Contract
// R1 - two independent decoders, each turning one 10-bit half into a byte
// R2 - recognise comma 0011111 or 1100000 as the symbol boundary marker; the code looks for 0011111 only
// R3 - only the 0011111 comma moves the word boundary
// R4 - both bytes captured in a 16-bit register, valid at word clock rise
// R5 - low and high K flags show control byte versus ordinary data
// R6 - only K28.0-K28.7, K23.7, K27.7, K29.7, K30.7 are valid controls
// R7 - a decode error shows K0.0 with K flag on that byte only
// R8 - loss of signal drives all data and both K flags high
// R9 - enable low: serial out, data and low K flag go high impedance
// R10 - outside keeps the reference word clock running in power-down
// R11 - with PRBS enabled, check stream and drive pass flag low on error
// R12 - bit clock is ten times word clock, two bits per bit clock
// R13 - outside keeps the reference clock within 100 ppm, 1.6 to 2.7 Gbps
// R14 - loopback routes transmit stream inward and tri-states serial out
// R15 - PRBS with loopback gives a full-speed self-test on the pass flag
// R16 - power-on reset tri-states data and flags, word clock low, under 1 ms
// R17 - the test sequence is the seven-stage 127-bit maximal sequence
// R18 - least significant bit travels first, first bit lands on data bit zero
// R19 - keep the boundary until a comma arrives at another position
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module rcad_rx_align
#(
  parameter int POR_CYCLES = rcad_pkg::POR_CYCLES
)
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic             irq_o,
  // serial side
  input  wire logic        serial_in_i,
  input  wire logic        sig_detect_i,
  input  wire logic        tx_serial_i,
  output logic             serial_out_pos_o,
  output logic             serial_out_neg_o,
  output logic             serial_out_oe_o,
  // parallel receive side
  output logic             rx_word_clk_o,
  output logic             bit_clk_o,
  output logic      [15:0] rx_data_o,
  output logic             rx_data_oe_o,
  output logic             rx_kflag_low_o,
  output logic             rx_kflag_low_oe_o,
  output logic             rx_kflag_high_o,
  output logic             rx_kflag_high_oe_o
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [2:0]  ctrl;
  logic [4:0]  status;
  logic [4:0]  mask;
  logic [31:0] por_cnt;
  logic        por_done;
  logic [19:0] sh;
  logic [4:0]  ph;
  logic        aligned;
  logic        prbs_acc;
  logic        los_q;
  logic        kflag_low;
  logic        prbs_pass;

  logic        enable;
  logic        prbs_en;
  logic        loop_en;
  logic        signal_lost;
  logic        bit_src;
  logic [19:0] next_sh;
  logic        comma_hit;
  logic        at_bound;
  logic        realign;
  logic        word_done;
  logic [4:0]  next_ph;
  logic        prbs_bit_err;
  logic        word_prbs_err;
  logic        dec_err;
  logic [15:0] next_data;
  logic [4:0]  events;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_mask;
  logic [31:0] next_rdata;
  logic [7:0]  dec_byte [2];
  logic [1:0]  dec_k;
  logic [1:0]  dec_bad;

  //////////////////////////////////////////////////////////////////////////////
  // control decode

  // control bits steer the datapath directly
  assign enable  = ctrl[rcad_pkg::CTRL_ENABLE];
  assign prbs_en = ctrl[rcad_pkg::CTRL_PRBS];
  assign loop_en = ctrl[rcad_pkg::CTRL_LOOP];
  assign signal_lost     = ~sig_detect_i;

  //////////////////////////////////////////////////////////////////////////////
  // power-on reset sequencing

  // counts clock cycles after reset release; data, flag, serial out and word clock pins stay parked until it ends
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      por_cnt  <= 32'h0;
      por_done <= 1'b0;
    end
    else if (!por_done)
    begin
      por_cnt  <= por_cnt + 32'h1;
      por_done <= (por_cnt == 32'(POR_CYCLES - 1));                    // see R16
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial source and shifter

  // loopback takes the transmit stream instead of the line
  assign bit_src = loop_en ? tx_serial_i : serial_in_i;                // see R14
  // newest bit enters at the top, so the oldest ends in bit 0
  assign next_sh = {bit_src, sh[19:1]};                                // see R18

  // shift one bit per cycle, two bits per bit clock period
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sh <= 20'h0;
    else
      sh <= next_sh;
  end

  //////////////////////////////////////////////////////////////////////////////
  // comma search and word framing

  // the comma's first bit is six bits back from the newest one
  assign comma_hit = (next_sh[19:13] == rcad_pkg::COMMA_PAT);         // see R2
  // the inverted comma is deliberately not looked for
  assign at_bound  = (ph == rcad_pkg::PH_ALIGN) || (ph == rcad_pkg::PH_ALIGN_HI);
  // a comma already on a symbol edge leaves the frame alone
  assign realign   = comma_hit && !at_bound && !signal_lost;                   // see R3
  assign word_done = (ph == rcad_pkg::PH_LAST) && !realign;
  assign next_ph   = realign ? rcad_pkg::PH_ALIGN + 5'h1 :              // see R19
                     (ph == rcad_pkg::PH_LAST) ? 5'h0 : ph + 5'h1;

  // bit index within the word; twenty steps make one word clock
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ph      <= 5'h0;
      aligned <= 1'b0;
    end
    else
    begin
      ph      <= next_ph;                                              // see R12
      aligned <= signal_lost ? 1'b0 : (aligned | comma_hit);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoder slices

  // one slice per 10-bit half of the word
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_dec
      rcad_dec_if dif ();
      assign dif.code   = next_sh[10*i +: 10];                         // see R1
      assign dec_byte[i] = dif.data;
      assign dec_k[i]    = dif.kflag;
      assign dec_bad[i]  = dif.err;
      rcad_decoder u_dec
      (
        .d (dif.dec)
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // pseudorandom checker

  // self-synchronising x^7 + x^6 + 1 check against the last seven bits
  assign prbs_bit_err  = bit_src ^ sh[14] ^ sh[13];                    // see R17
  assign word_prbs_err = prbs_acc | prbs_bit_err;

  // collect mismatches over one word
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      prbs_acc <= 1'b0;
    else if (word_done || realign)
      prbs_acc <= 1'b0;
    else
      prbs_acc <= prbs_acc | prbs_bit_err;
  end

  //////////////////////////////////////////////////////////////////////////////
  // output word register

  assign dec_err   = |dec_bad;
  // loss of signal overrides both bytes
  assign next_data = signal_lost ? rcad_pkg::LOS_WORD : {dec_byte[1], dec_byte[0]}; // see R8

  // captured once per word, five cycles before the word clock rises
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_data_o       <= 16'h0;
      kflag_low       <= 1'b0;
      rx_kflag_high_o <= 1'b0;
      prbs_pass       <= 1'b1;
    end
    else if (word_done)
    begin
      rx_data_o       <= next_data;                                    // see R4
      kflag_low       <= signal_lost | dec_k[0];                               // see R5
      rx_kflag_high_o <= signal_lost | dec_k[1];                               // see R8
      prbs_pass       <= !(prbs_en && word_prbs_err);                  // see R11
    end
  end

  // the low flag doubles as the pass indication in test mode
  assign rx_kflag_low_o = prbs_en ? prbs_pass : kflag_low;             // see R15

  //////////////////////////////////////////////////////////////////////////////
  // pin enables and clocks

  // power-down and power-on reset both release the data pins
  assign rx_data_oe_o       = enable && por_done;                      // see R9
  assign rx_kflag_low_oe_o  = enable && por_done;                      // see R9
  // the high flag stays driven in power-down so loss of signal stays visible
  assign rx_kflag_high_oe_o = por_done;                                // see R16
  assign serial_out_pos_o   = tx_serial_i;
  assign serial_out_neg_o   = ~tx_serial_i;
  assign serial_out_oe_o    = enable && !loop_en && por_done;          // see R14
  // word clock high for the middle half of the word so data settle before the rise
  assign rx_word_clk_o      = por_done && (ph >= rcad_pkg::PH_CLK_RISE) &&
                              (ph < rcad_pkg::PH_CLK_FALL);            // see R16
  assign bit_clk_o          = ph[0];                                   // see R12

  //////////////////////////////////////////////////////////////////////////////
  // events and interrupt

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      los_q <= 1'b0;
    else
      los_q <= signal_lost;
  end

  assign events[rcad_pkg::ST_REALIGN]  = realign;
  assign events[rcad_pkg::ST_DEC_ERR]  = word_done && !signal_lost && dec_err;
  assign events[rcad_pkg::ST_LOS]      = signal_lost && !los_q;
  assign events[rcad_pkg::ST_PRBS_ERR] = word_done && prbs_en && word_prbs_err;
  assign events[rcad_pkg::ST_POR_DONE] = !por_done && (por_cnt == 32'(POR_CYCLES - 1));

  assign wr_ctrl   = reg_wr_i && (reg_addr_i == rcad_pkg::ADDR_CTRL);
  assign wr_status = reg_wr_i && (reg_addr_i == rcad_pkg::ADDR_STATUS);
  assign wr_mask   = reg_wr_i && (reg_addr_i == rcad_pkg::ADDR_MASK);

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      status <= 5'h0;
    else
      status <= (status & ~(wr_status ? reg_wdata_i[4:0] : 5'h0)) | events;
  end

  assign irq_o = |(status & mask);

  //////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl <= rcad_pkg::CTRL_RST;
      mask <= rcad_pkg::MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= reg_wdata_i[2:0];
      if (wr_mask)
        mask <= reg_wdata_i[4:0];
    end
  end

  // unmapped addresses read as zero
  always_comb
  begin
    next_rdata = 32'h0;
    unique case (reg_addr_i)
      rcad_pkg::ADDR_CTRL:   next_rdata = {29'h0, ctrl};
      rcad_pkg::ADDR_STATUS: next_rdata = {27'h0, status};
      rcad_pkg::ADDR_MASK:   next_rdata = {27'h0, mask};
      rcad_pkg::ADDR_STATE:  next_rdata = {24'h0, ph, aligned, signal_lost, por_done};
      default:               next_rdata = 32'h0;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 32'h0;
    else
      reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_realign;
    realign |=> (ph == rcad_pkg::PH_ALIGN + 5'h1) ##12 ((ph == rcad_pkg::PH_LAST) || $past(realign));
  endproperty
  a_realign: assert property (p_realign) else $error("frame not moved to comma"); // see R19

  property p_no_move;
    (!realign && ph != rcad_pkg::PH_LAST) |=> ph == $past(ph) + 5'h1;
  endproperty
  a_no_move: assert property (p_no_move) else $error("frame moved without comma"); // see R3

  property p_los_word;
    (word_done && signal_lost) |=> (rx_data_o == rcad_pkg::LOS_WORD) && rx_kflag_high_o;
  endproperty
  a_los_word: assert property (p_los_word) else $error("loss of signal word wrong"); // see R8

  property p_dec_err;
    (word_done && !signal_lost && dec_bad[0]) |=> (rx_data_o[7:0] == rcad_pkg::K_ERR_BYTE) && kflag_low;
  endproperty
  a_dec_err: assert property (p_dec_err) else $error("error byte not K0.0"); // see R7

  property p_pdown;
    !enable |-> !rx_data_oe_o && !rx_kflag_low_oe_o && !serial_out_oe_o;
  endproperty
  a_pdown: assert property (p_pdown) else $error("pins driven in power-down"); // see R9

  property p_loop;
    loop_en |-> !serial_out_oe_o;
  endproperty
  a_loop: assert property (p_loop) else $error("serial out driven in loopback"); // see R14

  property p_por;
    !por_done |-> !rx_word_clk_o && !rx_kflag_high_oe_o && !rx_data_oe_o;
  endproperty
  a_por: assert property (p_por) else $error("pins active in power-on reset"); // see R16

  property p_prbs;
    (word_done && prbs_en && word_prbs_err) |=> !rx_kflag_low_o || !prbs_en;
  endproperty
  a_prbs: assert property (p_prbs) else $error("prbs error not flagged"); // see R11

endmodule

// *** rcad_tx_model.sv ***
// rcad_tx_model: far-end 8b/10b serial transmitter, or a local prbs source.
// assumes the bench holds a 20-bit coded word on word_i; words run back to back.
`timescale 1ns/1ps
module rcad_tx_model
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bench control
  input  wire logic [19:0] word_i,
  input  wire logic        prbs_i,
  input  wire logic        slip_i,
  // serial line
  output logic             bit_o
);
  logic [4:0]  cnt;
  logic [19:0] sh;
  logic [6:0]  lfsr;
  wire  logic  fb = lfsr[6] ^ lfsr[5];
  //////////////////////////////////////////
  // one bit per clock; a slip repeats the bit on the line, the only fault
  // this model makes, and only when the bench asks for it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt   <= 5'h00;
      sh    <= 20'h00000;
      lfsr  <= 7'h7f;
      bit_o <= 1'b0;
    end
    else if (prbs_i)
    begin
      lfsr  <= {lfsr[5:0], fb};
      bit_o <= fb;
    end
    else if (!slip_i)
    begin
      bit_o <= (cnt == 5'h00) ? word_i[0] : sh[1];
      sh    <= (cnt == 5'h00) ? word_i : {1'b0, sh[19:1]};
      cnt   <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
    end
  end
endmodule

// *** testbench.sv ***
// testbench: receive aligner fed by a line transmitter and a local transmitter.
// assumes a 200 MHz clock; the power-on count is cut to POR cycles.
`timescale 1ns/1ps
module testbench;
  // codes are written bit a first; wd reverses them for the line
  localparam int         POR   = 40;
  localparam logic [9:0] K285  = 10'h0fa;
  localparam logic [9:0] K285P = 10'h305;
  localparam logic [9:0] D000  = 10'h274;
  localparam logic [9:0] KC [12] = '{10'h0f4, 10'h0f9, 10'h0f5, 10'h0f3, 10'h0f2, 10'h0fa,
                                     10'h0f6, 10'h0f8, 10'h3a8, 10'h368, 10'h2e8, 10'h1e8};
  localparam logic [7:0] KB [12] = '{8'h1c, 8'h3c, 8'h5c, 8'h7c, 8'h9c, 8'hbc, 8'hdc, 8'hfc,
                                     8'hf7, 8'hfb, 8'hfd, 8'hfe};
  logic        ref_clk_i, rst_i, wr_s, rd_s, sig_det, slip, loc_prbs;
  logic        irq, line_bit, tx_bit, sop, son, soe, wclk, bclk;
  logic        rxd_oe, kl, kl_oe, kh, kh_oe;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rd;
  logic [19:0] line_word, loc_word;
  logic [15:0] rxd;
  int          bad_count, tests_run, cyc;
  //////////////////////////////////////////
  rcad_rx_align #(.POR_CYCLES(POR)) i_rcad_rx_align
  (
    .ref_clk_i (ref_clk_i), .rst_i (rst_i), .reg_addr_i (addr), .reg_wdata_i (wdata),
    .reg_wr_i (wr_s), .reg_rd_i (rd_s), .reg_rdata_o (rdata), .irq_o (irq),
    .serial_in_i (line_bit), .sig_detect_i (sig_det), .tx_serial_i (tx_bit),
    .serial_out_pos_o (sop), .serial_out_neg_o (son), .serial_out_oe_o (soe),
    .rx_word_clk_o (wclk), .bit_clk_o (bclk), .rx_data_o (rxd), .rx_data_oe_o (rxd_oe),
    .rx_kflag_low_o (kl), .rx_kflag_low_oe_o (kl_oe), .rx_kflag_high_o (kh),
    .rx_kflag_high_oe_o (kh_oe)
  );
  rcad_tx_model i_rcad_tx_model
  (
    .clk_i (ref_clk_i), .rst_i (rst_i), .word_i (line_word), .prbs_i (1'b0), .slip_i (slip),
    .bit_o (line_bit)
  );
  rcad_tx_model i_rcad_tx_model_loc
  (
    .clk_i (ref_clk_i), .rst_i (rst_i), .word_i (loc_word), .prbs_i (loc_prbs), .slip_i (1'b0),
    .bit_o (tx_bit)
  );
  //////////////////////////////////////////
  // the reference clock never stops, power-down included
  always #2.5 ref_clk_i = ~ref_clk_i;
  function automatic logic [9:0] rev(input logic [9:0] c);
    for (int i = 0; i < 10; i++)
      rev[i] = c[9 - i];
  endfunction
  function automatic logic [19:0] wd(input logic [9:0] hi, input logic [9:0] lo);
    return {rev(hi), rev(lo)};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // data is settled 5 cycles before the word clock rises, so judge it there
  task automatic wait_rise();
    logic o;
    o = wclk;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk_i);
      if (o === 1'b0 && wclk === 1'b1)
        break;
      o = wclk;
    end
  endtask
  task automatic wait_words(input int n);
    repeat (n) wait_rise();
  endtask
  task automatic chk_word(input logic [15:0] d, input logic l, input logic h);
    wait_rise();
    chk("rx word", {h, l, d}, {kh, kl, rxd});
  endtask
  // register port: strobe for one cycle, then one idle edge
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge ref_clk_i);
    wr_s  <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk_i);
    rd_s <= 1'b0;
    @(posedge ref_clk_i);
    d = rdata;
  endtask
  //////////////////////////////////////////
  task automatic t_por();
    logic o;
    int   n;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("oe in por", 5'h00, {rxd_oe, kl_oe, kh_oe, soe, wclk});
    repeat (POR + 4) @(posedge ref_clk_i);
    chk("oe after por", 4'hf, {rxd_oe, kl_oe, kh_oe, soe});
    n = 0;
    repeat (20)
    begin
      @(posedge ref_clk_i);
      if (wclk === 1'b1)
        n++;
    end
    chk("word clock high", 10, n);
    o = bclk;
    @(posedge ref_clk_i);
    chk("bit clock", !o, bclk);
    $display("test por done");
  endtask
  task automatic t_regs();
    reg_rd(rcad_pkg::ADDR_CTRL, rd);
    chk("ctrl reset", {29'h0, rcad_pkg::CTRL_RST}, rd);
    reg_rd(rcad_pkg::ADDR_MASK, rd);
    chk("mask reset", {27'h0, rcad_pkg::MASK_RST}, rd);
    reg_rd(8'h10, rd);
    chk("unmapped", 32'h0, rd);
    reg_rd(rcad_pkg::ADDR_STATE, rd);
    chk("state aligned", 3'h5, rd[2:0]);
    reg_rd(rcad_pkg::ADDR_STATUS, rd);
    chk("por event", 1, rd[rcad_pkg::ST_POR_DONE]);
    chk("irq masked", 0, irq);
    reg_wr(rcad_pkg::ADDR_MASK, 32'h1 << rcad_pkg::ST_POR_DONE);
    chk("irq raised", 1, irq);
    reg_wr(rcad_pkg::ADDR_STATUS, 32'h1 << rcad_pkg::ST_POR_DONE);
    chk("irq cleared", 0, irq);
    reg_wr(rcad_pkg::ADDR_MASK, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_decode();
    chk_word(16'h00bc, 1'b1, 1'b0);
    for (int i = 0; i < 12; i++)
    begin
      line_word <= wd(KC[i], K285);
      wait_words(3);
      chk_word({KB[i], 8'hbc}, 1'b1, 1'b1);
    end
    line_word <= wd(10'h000, K285);
    wait_words(3);
    chk_word({rcad_pkg::K_ERR_BYTE, 8'hbc}, 1'b1, 1'b1);
    $display("test decode done");
  endtask
  // a slipped bit plus only inverse commas must leave the boundary alone
  task automatic t_align();
    line_word <= wd(D000, K285P);
    wait_words(3);
    reg_wr(rcad_pkg::ADDR_STATUS, 32'h1f);
    slip <= 1'b1;
    @(posedge ref_clk_i);
    slip <= 1'b0;
    wait_words(4);
    reg_rd(rcad_pkg::ADDR_STATUS, rd);
    chk("inverse comma", 0, rd[rcad_pkg::ST_REALIGN]);
    line_word <= wd(D000, K285);
    wait_words(3);
    reg_rd(rcad_pkg::ADDR_STATUS, rd);
    chk("realign", 1, rd[rcad_pkg::ST_REALIGN]);
    chk_word(16'h00bc, 1'b1, 1'b0);
    $display("test align done");
  endtask
  task automatic t_los();
    sig_det <= 1'b0;
    wait_words(3);
    chk_word(rcad_pkg::LOS_WORD, 1'b1, 1'b1);
    reg_rd(rcad_pkg::ADDR_STATE, rd);
    chk("state in los", 3'h3, rd[2:0]);
    sig_det <= 1'b1;
    wait_words(3);
    chk_word(16'h00bc, 1'b1, 1'b0);
    $display("test los done");
  endtask
  task automatic t_pwr();
    reg_wr(rcad_pkg::ADDR_CTRL, 32'h0);
    chk("oe power down", 4'h1, {rxd_oe, kl_oe, soe, kh_oe});
    reg_wr(rcad_pkg::ADDR_CTRL, 32'h1);
    chk("oe enabled", 4'hf, {rxd_oe, kl_oe, soe, kh_oe});
    $display("test power done");
  endtask
  task automatic t_loop();
    @(negedge ref_clk_i);
    chk("serial out", {1'b1, tx_bit, !tx_bit}, {soe, sop, son});
    @(posedge ref_clk_i);
    reg_wr(rcad_pkg::ADDR_CTRL, 32'h5);
    chk("serial out off", 0, soe);
    wait_words(3);
    chk_word(16'hfebc, 1'b1, 1'b1);
    $display("test loop done");
  endtask
  task automatic t_prbs();
    loc_prbs <= 1'b1;
    reg_wr(rcad_pkg::ADDR_CTRL, 32'h7);
    wait_words(3);
    for (int i = 0; i < 3; i++)
    begin
      wait_rise();
      chk("self test pass", 1, kl);
    end
    reg_wr(rcad_pkg::ADDR_CTRL, 32'h3);
    wait_words(3);
    chk("prbs error", 0, kl);
    loc_prbs <= 1'b0;
    reg_wr(rcad_pkg::ADDR_CTRL, 32'h1);
    $display("test prbs done");
  endtask
  //////////////////////////////////////////
  initial
  begin
    ref_clk_i = 1'b0;
    rst_i     = 1'b1;
    wr_s      = 1'b0;
    rd_s      = 1'b0;
    addr      = 8'h00;
    wdata     = 32'h0;
    sig_det   = 1'b1;
    slip      = 1'b0;
    loc_prbs  = 1'b0;
    line_word = wd(D000, K285);
    loc_word  = wd(10'h1e8, K285);
    t_por();
    t_regs();
    t_decode();
    t_align();
    t_los();
    t_pwr();
    t_loop();
    t_prbs();
    close_out();
  end
  // a hang is cut short well past the expected run length
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      close_out();
    end
  end
endmodule
